/* File: verilog/amss_pkg.sv */
// Package of constants for the async memory strobe sequencer
package amss_pkg;
  localparam int ADDR_W        = 21;
  localparam int BANK_W        = 2;
  localparam int DATA_W        = 16;
  localparam int CS_W          = 4;
  localparam int SETUP_W       = 4;
  localparam int STROBE_W      = 6;
  localparam int HOLD_W        = 3;
  localparam int TA_W          = 2;
  localparam int WAITMAX_W     = 8;
  localparam int EWC_W         = 8;
  // Time units added per external wait cycle
  localparam int EWC_UNITS     = 16;
  // Time units from wait release to strobe end
  localparam int RELEASE_UNITS = 4;
  localparam int TICK_RST      = 0;
  typedef enum logic [2:0] {
    AMSS_IDLE    = 3'b000,
    AMSS_SETUP   = 3'b001,
    AMSS_STROBE  = 3'b010,
    AMSS_EXTWAIT = 3'b011,
    AMSS_RELEASE = 3'b100,
    AMSS_HOLD    = 3'b101,
    AMSS_TURN    = 3'b110
  } amss_state_t;
endpackage

/* File: verilog/amss_tick.sv */
// Time-unit tick generator: full or half system clock rate
`timescale 1ns/1ps
module amss_tick
(
  // Clock and reset
  input  wire logic I_CLK,
  input  wire logic I_SRST,
  // Rate select and tick
  input  wire logic i_half_rate,
  output logic      o_tick
);
  logic tog_r;
  logic tog_nxt;

  always_comb
  begin
    tog_nxt = i_half_rate ? ~tog_r : 1'b1;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      tog_r <= 1'(amss_pkg::TICK_RST);
    else
      tog_r <= tog_nxt;
  end

  // One tick per unit: every clock at full rate, every second at half
  assign o_tick = i_half_rate ? tog_r : 1'b1;
endmodule // amss_tick

/* File: verilog/amss_sequencer.sv */
// Async memory strobe sequencer for SRAM and NOR flash
// Function
// - Read lasts setup plus strobe plus hold time units without waiting.
// - With waiting, read grows sixteen units per external wait cycle.
// - Write lasts setup plus strobe plus hold time units without waiting.
// - With waiting, write grows sixteen units per external wait cycle.
// - Select-strobe off: chip select leads read strobe by read setup.
// - Select-strobe on: chip select falls and rises with the strobe.
// - Select-strobe off: chip select stays read hold after read strobe.
// - Read address and bank valid setup before, held hold after strobe.
// - Without waiting, read strobe low exactly read strobe count units.
// - Strobe ends four time units after wait input releases.
// - Select-strobe off: chip select leads write strobe by write setup.
// - Select-strobe off: chip select stays write hold after write strobe.
// - Write address and bank valid setup before, held hold after strobe.
// - Time unit is one clock at full rate, two at half rate.
// - External wait cycles bounded by programmable maximum; excess times out.
// - Turnaround, setup, strobe, hold and max wait are programmable.
`timescale 1ns/1ps
module amss_sequencer
#(
  parameter int CS_W = amss_pkg::CS_W
)
(
  // Clock and reset
  input  wire logic                         I_CLK,
  input  wire logic                         I_SRST,
  // Configuration
  input  wire logic                         I_HALF_RATE,
  input  wire logic                         I_SELECT_STROBE,
  input  wire logic                         I_EXTENDED_WAIT_ENABLE,
  input  wire logic                         I_WAIT_POLARITY_HIGH,
  input  wire logic [amss_pkg::SETUP_W-1:0]   I_READ_SETUP_COUNT,
  input  wire logic [amss_pkg::STROBE_W-1:0]  I_READ_STROBE_COUNT,
  input  wire logic [amss_pkg::HOLD_W-1:0]    I_READ_HOLD_COUNT,
  input  wire logic [amss_pkg::SETUP_W-1:0]   I_WRITE_SETUP_COUNT,
  input  wire logic [amss_pkg::STROBE_W-1:0]  I_WRITE_STROBE_COUNT,
  input  wire logic [amss_pkg::HOLD_W-1:0]    I_WRITE_HOLD_COUNT,
  input  wire logic [amss_pkg::TA_W-1:0]      I_TURNAROUND_COUNT,
  input  wire logic [amss_pkg::WAITMAX_W-1:0] I_MAX_EXT_WAIT_CYCLES,
  // Request side
  input  wire logic                         I_REQ_VALID,
  input  wire logic                         I_REQ_WRITE,
  input  wire logic [CS_W-1:0]              I_REQ_CS,
  input  wire logic [amss_pkg::ADDR_W-1:0]  I_REQ_ADDR,
  input  wire logic [amss_pkg::BANK_W-1:0]  I_REQ_BANK,
  input  wire logic [amss_pkg::DATA_W-1:0]  I_REQ_WDATA,
  output logic                              O_REQ_READY,
  output logic                              O_DONE,
  output logic                              O_TIMEOUT,
  output logic [amss_pkg::DATA_W-1:0]       O_RDATA,
  output logic [amss_pkg::EWC_W-1:0]        O_EXT_WAIT_CYCLES,
  output logic                              O_BUSY,
  // Memory pins
  input  wire logic                         I_EXT_WAIT_IN,
  output logic [CS_W-1:0]                   O_CHIP_SELECT_N,
  output logic                              O_READ_STROBE_N,
  output logic                              O_WRITE_STROBE_N,
  output logic [amss_pkg::ADDR_W-1:0]       O_MEM_ADDR_OUT,
  output logic [amss_pkg::BANK_W-1:0]       O_BANK_SELECT,
  input  wire logic [amss_pkg::DATA_W-1:0]  I_MEM_DATA_BUS,
  output logic [amss_pkg::DATA_W-1:0]       O_MEM_DATA_BUS,
  output logic                              O_MEM_DATA_OE
);
  localparam int CNT_W = 8;

  amss_pkg::amss_state_t state_r, state_nxt;
  logic [CNT_W-1:0]               cnt_r, cnt_nxt;
  logic [3:0]                     sub_r, sub_nxt;
  logic [amss_pkg::EWC_W-1:0]     ewc_r, ewc_nxt;
  logic                           wr_r, wr_nxt;
  logic [CS_W-1:0]                cs_r, cs_nxt;
  logic [amss_pkg::ADDR_W-1:0]    addr_r, addr_nxt;
  logic [amss_pkg::BANK_W-1:0]    bank_r, bank_nxt;
  logic [amss_pkg::DATA_W-1:0]    wdata_r, wdata_nxt;
  logic [amss_pkg::DATA_W-1:0]    rdata_r, rdata_nxt;
  logic                           done_r, done_nxt;
  logic                           tmo_r, tmo_nxt;
  logic                           cs_act_r, cs_act_nxt;
  logic                           rd_n_r, rd_n_nxt;
  logic                           wr_n_r, wr_n_nxt;
  logic                           oe_r, oe_nxt;
  logic                           wait_s1_r, wait_s2_r;
  logic                           tick;
  logic                           wait_act;

  amss_tick u_tick
  (
    .I_CLK       (I_CLK),
    .I_SRST      (I_SRST),
    .i_half_rate (I_HALF_RATE),
    .o_tick      (tick)
  );

  // Two-stage synchroniser on the wait pin
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      wait_s1_r <= 1'b0;
      wait_s2_r <= 1'b0;
    end
    else
    begin
      wait_s1_r <= I_EXT_WAIT_IN;
      wait_s2_r <= wait_s1_r;
    end
  end

  assign wait_act = (wait_s2_r == I_WAIT_POLARITY_HIGH);

  // Load a phase counter; zero counts are stretched to one unit
  function automatic logic [CNT_W-1:0] ld(input logic [CNT_W-1:0] v);
    ld = (v == '0) ? CNT_W'(1) : v;
  endfunction

  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    sub_nxt    = sub_r;
    ewc_nxt    = ewc_r;
    wr_nxt     = wr_r;
    cs_nxt     = cs_r;
    addr_nxt   = addr_r;
    bank_nxt   = bank_r;
    wdata_nxt  = wdata_r;
    rdata_nxt  = rdata_r;
    done_nxt   = 1'b0;
    tmo_nxt    = 1'b0;
    cs_act_nxt = cs_act_r;
    rd_n_nxt   = rd_n_r;
    wr_n_nxt   = wr_n_r;
    oe_nxt     = oe_r;
    case (state_r)
      amss_pkg::AMSS_IDLE:
      begin
        if (I_REQ_VALID && tick)
        begin
          wr_nxt     = I_REQ_WRITE;
          cs_nxt     = I_REQ_CS;
          addr_nxt   = I_REQ_ADDR;
          bank_nxt   = I_REQ_BANK;
          wdata_nxt  = I_REQ_WDATA;
          oe_nxt     = I_REQ_WRITE;
          ewc_nxt    = '0;
          cs_act_nxt = ~I_SELECT_STROBE;
          cnt_nxt    = ld(CNT_W'(I_REQ_WRITE ? I_WRITE_SETUP_COUNT
                                             : I_READ_SETUP_COUNT));
          state_nxt  = amss_pkg::AMSS_SETUP;
        end
      end
      amss_pkg::AMSS_SETUP:
      begin
        if (tick)
        begin
          cnt_nxt = cnt_r - CNT_W'(1);
          if (cnt_r == CNT_W'(1))
          begin
            cs_act_nxt = 1'b1;
            rd_n_nxt   = wr_r;
            wr_n_nxt   = ~wr_r;
            cnt_nxt    = ld(CNT_W'(wr_r ? I_WRITE_STROBE_COUNT
                                        : I_READ_STROBE_COUNT));
            state_nxt  = amss_pkg::AMSS_STROBE;
          end
        end
      end
      amss_pkg::AMSS_STROBE:
      begin
        if (tick)
        begin
          cnt_nxt = cnt_r - CNT_W'(1);
          if (cnt_r == CNT_W'(1))
          begin
            if (I_EXTENDED_WAIT_ENABLE && wait_act)
            begin
              ewc_nxt   = amss_pkg::EWC_W'(1);
              sub_nxt   = 4'(amss_pkg::EWC_UNITS - 1);
              state_nxt = amss_pkg::AMSS_EXTWAIT;
            end
            else
            begin
              // strobe ends after exactly the count
              rdata_nxt = I_MEM_DATA_BUS;
              rd_n_nxt  = 1'b1;
              wr_n_nxt  = 1'b1;
              cs_act_nxt = ~I_SELECT_STROBE;
              cnt_nxt   = ld(CNT_W'(wr_r ? I_WRITE_HOLD_COUNT
                                         : I_READ_HOLD_COUNT));
              state_nxt = amss_pkg::AMSS_HOLD;
            end
          end
        end
      end
      amss_pkg::AMSS_EXTWAIT:
      begin
        if (tick)
        begin
          sub_nxt = sub_r - 4'(1);
          if (!wait_act)
          begin
            cnt_nxt   = CNT_W'(amss_pkg::RELEASE_UNITS - 1);
            state_nxt = amss_pkg::AMSS_RELEASE;
          end
          else if (sub_r == 4'(0))
          begin
            sub_nxt = 4'(amss_pkg::EWC_UNITS - 1);
            if (ewc_r >= I_MAX_EXT_WAIT_CYCLES)
            begin
              tmo_nxt   = 1'b1;
              cnt_nxt   = CNT_W'(amss_pkg::RELEASE_UNITS - 1);
              state_nxt = amss_pkg::AMSS_RELEASE;
            end
            else
              ewc_nxt = ewc_r + amss_pkg::EWC_W'(1);
          end
        end
      end
      amss_pkg::AMSS_RELEASE:
      begin
        if (tick)
        begin
          cnt_nxt = cnt_r - CNT_W'(1);
          if (cnt_r == CNT_W'(0))
          begin
            rdata_nxt  = I_MEM_DATA_BUS;
            rd_n_nxt   = 1'b1;
            wr_n_nxt   = 1'b1;
            cs_act_nxt = ~I_SELECT_STROBE;
            cnt_nxt    = ld(CNT_W'(wr_r ? I_WRITE_HOLD_COUNT
                                        : I_READ_HOLD_COUNT));
            state_nxt  = amss_pkg::AMSS_HOLD;
          end
        end
      end
      amss_pkg::AMSS_HOLD:
      begin
        if (tick)
        begin
          cnt_nxt = cnt_r - CNT_W'(1);
          if (cnt_r == CNT_W'(1))
          begin
            cs_act_nxt = 1'b0;
            oe_nxt     = 1'b0;
            done_nxt   = 1'b1;
            cnt_nxt    = CNT_W'(I_TURNAROUND_COUNT);
            state_nxt  = (I_TURNAROUND_COUNT == '0) ? amss_pkg::AMSS_IDLE
                                                    : amss_pkg::AMSS_TURN;
          end
        end
      end
      amss_pkg::AMSS_TURN:
      begin
        if (tick)
        begin
          cnt_nxt = cnt_r - CNT_W'(1);
          if (cnt_r == CNT_W'(1))
            state_nxt = amss_pkg::AMSS_IDLE;
        end
      end
      default:
        state_nxt = amss_pkg::AMSS_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      state_r  <= amss_pkg::AMSS_IDLE;
      cnt_r    <= '0;
      sub_r    <= '0;
      ewc_r    <= '0;
      wr_r     <= 1'b0;
      cs_r     <= '0;
      addr_r   <= '0;
      bank_r   <= '0;
      wdata_r  <= '0;
      rdata_r  <= '0;
      done_r   <= 1'b0;
      tmo_r    <= 1'b0;
      cs_act_r <= 1'b0;
      rd_n_r   <= 1'b1;
      wr_n_r   <= 1'b1;
      oe_r     <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      sub_r    <= sub_nxt;
      ewc_r    <= ewc_nxt;
      wr_r     <= wr_nxt;
      cs_r     <= cs_nxt;
      addr_r   <= addr_nxt;
      bank_r   <= bank_nxt;
      wdata_r  <= wdata_nxt;
      rdata_r  <= rdata_nxt;
      done_r   <= done_nxt;
      tmo_r    <= tmo_nxt;
      cs_act_r <= cs_act_nxt;
      rd_n_r   <= rd_n_nxt;
      wr_n_r   <= wr_n_nxt;
      oe_r     <= oe_nxt;
    end
  end

  assign O_REQ_READY       = (state_r == amss_pkg::AMSS_IDLE) && tick;
  assign O_BUSY            = (state_r != amss_pkg::AMSS_IDLE);
  assign O_DONE            = done_r;
  assign O_TIMEOUT         = tmo_r;
  assign O_RDATA           = rdata_r;
  assign O_EXT_WAIT_CYCLES = ewc_r;
  assign O_CHIP_SELECT_N   = cs_act_r ? ~cs_r : {CS_W{1'b1}};
  assign O_READ_STROBE_N   = rd_n_r;
  assign O_WRITE_STROBE_N  = wr_n_r;
  assign O_MEM_ADDR_OUT    = addr_r;
  assign O_BANK_SELECT     = bank_r;
  assign O_MEM_DATA_BUS    = wdata_r;
  assign O_MEM_DATA_OE     = oe_r;

  strobe_excl_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    !(!O_READ_STROBE_N && !O_WRITE_STROBE_N))
    else $error("both strobes low");
  cs_with_strobe_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (!O_READ_STROBE_N || !O_WRITE_STROBE_N) |-> (O_CHIP_SELECT_N != '1))
    else $error("strobe without chip select");
  addr_stable_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (state_r != amss_pkg::AMSS_IDLE && $past(state_r) != amss_pkg::AMSS_IDLE)
    |-> $stable(O_MEM_ADDR_OUT))
    else $error("address moved during access");
  no_wait_strobe_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (!I_EXTENDED_WAIT_ENABLE && $fell(O_READ_STROBE_N) && !I_HALF_RATE
     && I_READ_STROBE_COUNT == 6'(2))
    |-> !O_READ_STROBE_N ##1 !O_READ_STROBE_N ##1 O_READ_STROBE_N)
    else $error("read strobe width wrong");
  ss_cs_low_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (I_SELECT_STROBE && $fell(O_WRITE_STROBE_N))
    |-> !$past(cs_act_r) && cs_act_r)
    else $error("select not with write strobe");
  done_idle_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_DONE |-> O_READ_STROBE_N && O_WRITE_STROBE_N && O_CHIP_SELECT_N == '1)
    else $error("done with pins active");
  wait_bound_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_BUSY |-> ewc_r <= I_MAX_EXT_WAIT_CYCLES || I_MAX_EXT_WAIT_CYCLES == '0)
    else $error("wait count beyond bound");
  release_end_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (state_r == amss_pkg::AMSS_EXTWAIT && tick && !wait_act && !I_HALF_RATE)
    |-> ##5 (O_READ_STROBE_N && O_WRITE_STROBE_N))
    else $error("strobe not ended after release");
  turn_gap_a: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (O_DONE && I_TURNAROUND_COUNT != '0) |-> !O_REQ_READY)
    else $error("no turnaround gap");
endmodule // amss_sequencer

/* File: verification/amss_mem_model.sv */
// Behavioural async SRAM model with a commanded wait output
`timescale 1ns/1ps
module amss_mem_model
(
  // Clock
  input  wire logic        i_clk,
  // Memory pins
  input  wire logic [3:0]  i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic [20:0] i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic        i_data_oe,
  output logic [15:0]      o_data,
  output logic             o_wait,
  // Wait length in clocks, zero for none
  input  wire logic [8:0]  i_wait_len
);
  logic [15:0] mem [16];
  logic        idle_r = 1'b1;
  logic [8:0]  cnt_r = 9'h000;
  logic        sel;
  assign sel = i_cs_n != 4'hF;
  initial o_data = 16'h5A5A;
  initial o_wait = 1'b0;
  always @(posedge i_clk)
  begin
    // Bus not read shows a pattern that flips every cycle
    o_data <= (!i_rd_n && sel) ? mem[i_addr[3:0]] : ~o_data;
    if (!i_wr_n && sel)
      mem[i_addr[3:0]] <= i_data_oe ? i_data : 16'hDEAD;
    // Wait raised as the strobe falls, well ahead of the hold phase
    if (idle_r && !(i_rd_n && i_wr_n) && i_wait_len != 9'h000)
    begin
      o_wait <= 1'b1;
      cnt_r  <= i_wait_len;
    end
    else if (cnt_r != 9'h000)
    begin
      cnt_r <= cnt_r - 9'h001;
      if (cnt_r == 9'h001)
        o_wait <= 1'b0;
    end
    idle_r <= i_rd_n && i_wr_n;
  end
endmodule // amss_mem_model

/* File: verification/test_amss_sequencer.sv */
// Self-checking testbench for the async memory strobe sequencer
`timescale 1ns/1ps
module test_amss_sequencer;
  logic I_CLK = 1'b0, I_SRST = 1'b1;
  logic hr = 1'b0, ss = 1'b0, ew = 1'b0, v = 1'b0, we = 1'b0;
  logic [3:0] rs = 4'h1, ws = 4'h3, cs = 4'h1, csn, csl;
  logic [5:0] rst = 6'h02, write_strobe_count = 6'h05;
  logic [2:0] rh = 3'h1, wh = 3'h2;
  logic [1:0] ta = 2'h0, ba = 2'h0, mb;
  logic [7:0] mx = 8'hFF, ext_wait_cycles;
  logic [20:0] a = 21'h0, ma;
  logic [15:0] wd = 16'h0, md, dq, rdat;
  logic [8:0] wl = 9'h000;
  logic rdy, done, tmo, busy, wt, rdn, wrn, oe;
  logic pc = 1'b1, ps = 1'b1, pw = 1'b0, tos = 1'b0, abad = 1'b0;
  logic [22:0] al;
  int cyc = 0, tcf, tsf, tsr, tcr = 0, twr, gap;
  int n_errors = 0, checks = 0;

  always #2.5 I_CLK = ~I_CLK;

  amss_sequencer DUT (
    .I_CLK(I_CLK), .I_SRST(I_SRST), .I_HALF_RATE(hr),
    .I_SELECT_STROBE(ss), .I_EXTENDED_WAIT_ENABLE(ew),
    .I_WAIT_POLARITY_HIGH(1'b1),
    .I_READ_SETUP_COUNT(rs), .I_READ_STROBE_COUNT(rst),
    .I_READ_HOLD_COUNT(rh), .I_WRITE_SETUP_COUNT(ws),
    .I_WRITE_STROBE_COUNT(write_strobe_count), .I_WRITE_HOLD_COUNT(wh),
    .I_TURNAROUND_COUNT(ta), .I_MAX_EXT_WAIT_CYCLES(mx),
    .I_REQ_VALID(v), .I_REQ_WRITE(we), .I_REQ_CS(cs), .I_REQ_ADDR(a),
    .I_REQ_BANK(ba), .I_REQ_WDATA(wd), .O_REQ_READY(rdy),
    .O_DONE(done), .O_TIMEOUT(tmo), .O_RDATA(rdat),
    .O_EXT_WAIT_CYCLES(ext_wait_cycles), .O_BUSY(busy), .I_EXT_WAIT_IN(wt),
    .O_CHIP_SELECT_N(csn), .O_READ_STROBE_N(rdn),
    .O_WRITE_STROBE_N(wrn), .O_MEM_ADDR_OUT(ma), .O_BANK_SELECT(mb),
    .I_MEM_DATA_BUS(md), .O_MEM_DATA_BUS(dq), .O_MEM_DATA_OE(oe));

  amss_mem_model MEM (
    .i_clk(I_CLK), .i_cs_n(csn), .i_rd_n(rdn), .i_wr_n(wrn),
    .i_addr(ma), .i_data(dq), .i_data_oe(oe), .o_data(md),
    .o_wait(wt), .i_wait_len(wl));

  // Edge times of the memory pins, in clocks
  always @(negedge I_CLK)
  begin
    cyc++;
    if (tmo)
      tos = 1'b1;
    if (pc)
      al = {mb, ma};
    if (csn != 4'hF)
      csl = csn;
    if (pc && csn != 4'hF)
      tcf = cyc;
    if (pc && csn != 4'hF)
      gap = cyc - tcr;
    if (!pc && csn == 4'hF)
      tcr = cyc;
    if (csn != 4'hF && {mb, ma} !== al)
      abad = 1'b1;
    if (ps && !(rdn && wrn))
      tsf = cyc;
    if (!ps && rdn && wrn)
      tsr = cyc;
    if (pw && !wt)
      twr = cyc;
    pc = csn == 4'hF;
    ps = rdn && wrn;
    pw = wt;
  end

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One access; returns one clock after the done pulse
  task automatic acc(logic w, logic [20:0] ad, logic [15:0] d, int c);
    int k = 0;
    @(negedge I_CLK);
    v = 1'b1;
    we = w;
    a = ad;
    wd = d;
    ba = ad[1:0];
    cs = 4'h1 << c;
    abad = 1'b0;
    csl = 4'h0;
    while (!rdy && k < 100)
    begin
      @(negedge I_CLK);
      k++;
    end
    @(negedge I_CLK);
    v = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 2000)
    begin
      @(negedge I_CLK);
      k++;
    end
    chk("done", done, 1);
    chk("cs_line", csl, 4'(~cs));
    @(negedge I_CLK);
    chk("turn_busy", busy, ta != 2'h0);
    chk("addr_stable", abad, 0);
    chk("addr_value", al, {ad[1:0], ad});
  endtask

  task automatic tim(int s, int st, int h, int e, logic sel);
    chk("lead", tsf - tcf, sel ? 0 : s * e);
    chk("width", tsr - tsf, st * e);
    chk("trail", tcr - tsr, sel ? 0 : h * e);
    chk("cycle", tcr - tcf, sel ? st * e : (s + st + h) * e);
  endtask

  initial
  begin
    repeat (8) @(negedge I_CLK);
    I_SRST = 1'b0;
    chk("idle_cs", csn, 4'hF);
    chk("idle_pins", {rdn, wrn, oe}, 3'b110);
    for (int i = 0; i < 4; i++)
    begin
      acc(1, 21'h00010 + i, 16'hA5C0 + i, i);
      tim(3, 5, 2, 1, 0);
      acc(0, 21'h00010 + i, 16'h0, i);
      tim(1, 2, 1, 1, 0);
      chk("rdata", rdat, 16'hA5C0 + i);
    end
    $display("test timing done");
    hr = 1'b1;
    acc(0, 21'h00011, 16'h0, 1);
    tim(1, 2, 1, 2, 0);
    hr = 1'b0;
    ss = 1'b1;
    acc(1, 21'h1FFFF3, 16'h3C5A, 2);
    tim(3, 5, 2, 1, 1);
    acc(0, 21'h1FFFF3, 16'h0, 2);
    tim(1, 2, 1, 1, 1);
    chk("rdata_sel", rdat, 16'h3C5A);
    ss = 1'b0;
    $display("test rate and select done");
    ta = 2'h2;
    acc(1, 21'h00004, 16'h0F0F, 0);
    acc(0, 21'h00004, 16'h0, 0);
    chk("gap", gap >= 2, 1);
    ta = 2'h0;
    $display("test turnaround done");
    ew = 1'b1;
    rst = 6'h08;
    write_strobe_count = 6'h08;
    wl = 9'd40;
    for (int w = 1; w >= 0; w--)
    begin
      acc(w[0], 21'h00006, 16'h6006, 3);
      chk("rel_lo", tsr - twr >= 4, 1);
      chk("rel_hi", tsr - twr <= 7, 1);
      chk("ewc", ext_wait_cycles != 0, 1);
      // Last counted block is cut short by the release, then 4 units
      chk("ext_lo", tsr - tsf > 12 + 16 * (ext_wait_cycles - 1), 1);
      chk("ext_hi", tsr - tsf <= 12 + 16 * ext_wait_cycles, 1);
    end
    chk("rdata_wait", rdat, 16'h6006);
    $display("test wait done");
    mx = 8'h01;
    wl = 9'd300;
    tos = 1'b0;
    acc(0, 21'h00006, 16'h0, 3);
    chk("timeout", tos, 1);
    chk("ewc_max", ext_wait_cycles <= 1, 1);
    $display("test timeout done");
    stop_test();
  end

  initial
  begin
    #50000;
    n_errors++;
    stop_test();
  end
endmodule // test_amss_sequencer
